// >>> src/svgl_pkg.sv
/*
 Shared constants and types for the nested servo gain loop.
 Assumes a 32-bit AHB-Lite register bus and signed fixed-point data.
*/
package svgl_pkg;
   // ----------------------------------------
   // Arithmetic formats
   // ----------------------------------------
   localparam int SVGL_W = 32;
   localparam int SVGL_G = 16;
   localparam int SVGL_F = 8;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam logic [7:0] ADDR_KPP = 8'h08;
   localparam logic [7:0] ADDR_KPI = 8'h0C;
   localparam logic [7:0] ADDR_KVP = 8'h10;
   localparam logic [7:0] ADDR_KVI = 8'h14;
   localparam logic [7:0] ADDR_KVFF = 8'h18;
   localparam logic [7:0] ADDR_KAFF = 8'h1C;
   localparam logic [7:0] ADDR_LIMIT = 8'h20;
   localparam logic [7:0] ADDR_OUT = 8'h24;
   localparam int CTRL_W = 4;
   localparam int STAT_SAT = 0;
   localparam int STAT_BUSY = 1;
   localparam int STAT_FREEZE = 2;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [15:0] GAIN_UNITY = 16'h0100;
   localparam logic [15:0] GAIN_ZERO = 16'h0000;
   localparam logic [31:0] LIMIT_RST = 32'h7FFF_FFFF;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef struct packed {
      logic fb_on;
      logic run_lock;
      logic torque_mode;
      logic hold_en;
   } svgl_ctrl_type;
   typedef struct packed {
      logic signed [SVGL_G-1:0] kpp;
      logic signed [SVGL_G-1:0] kpi;
      logic signed [SVGL_G-1:0] kvp;
      logic signed [SVGL_G-1:0] kvi;
      logic signed [SVGL_G-1:0] kvff;
      logic signed [SVGL_G-1:0] kaff;
   } svgl_gain_type;
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_PERR = 8'h02,
      ST_PINT = 8'h04,
      ST_VFF = 8'h08,
      ST_VLOOP = 8'h10,
      ST_VINT = 8'h20,
      ST_AFF = 8'h40,
      ST_OUT = 8'h80
   } svgl_state_type;
endpackage : svgl_pkg

// >>> src/svgl_sat_mac.sv
/*
 Saturating multiply-accumulate: y = clamp(acc + (a*g) >>> F).
 Assumes signed operands; purely combinational.
*/
`timescale 1ns/1ps
module svgl_sat_mac
   import svgl_pkg::*;
#(
   parameter int W = SVGL_W,
   parameter int G = SVGL_G,
   parameter int F = SVGL_F
) (
   input wire logic signed [W-1:0] acc,
   input wire logic signed [W-1:0] a,
   input wire logic signed [G-1:0] g,
   output logic signed [W-1:0] y,
   output logic sat
);
   localparam int P = W + G + 1;
   localparam logic signed [P-1:0] MAXV = P'({1'b0, {(W-1){1'b1}}});
   localparam logic signed [P-1:0] MINV = -MAXV - P'(1);
   if (F >= G || W < 8) begin : g_bad_format
      $error("svgl_sat_mac: bad format");
   end
   wire logic signed [W+G-1:0] prod = a * g;
   wire logic signed [P-1:0] sum = P'(acc) + P'(prod >>> F);
   wire logic hi = sum > MAXV;
   wire logic lo = sum < MINV;
   // Clamp, never wrap
   assign y = hi ? MAXV[W-1:0] : (lo ? MINV[W-1:0] : sum[W-1:0]);
   assign sat = hi | lo;
endmodule : svgl_sat_mac

// >>> src/svgl_integ.sv
/*
 Saturating error accumulator with freeze and clear.
 Assumes one step pulse per servo update.
*/
`timescale 1ns/1ps
module svgl_integ
   import svgl_pkg::*;
#(
   parameter int W = SVGL_W
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clr,
   input wire logic step,
   input wire logic signed [W-1:0] err,
   output logic signed [W-1:0] acc_reg
);
   localparam logic signed [W:0] MAXV = (W+1)'({1'b0, {(W-1){1'b1}}});
   if (W < 8) begin : g_bad_width
      $error("svgl_integ: width too small");
   end
   wire logic signed [W:0] sum = (W+1)'(acc_reg) + (W+1)'(err);
   wire logic signed [W-1:0] acc_next = (sum > MAXV) ? MAXV[W-1:0] :
      ((sum < -MAXV - (W+1)'(1)) ? (-MAXV[W-1:0] - W'(1)) : sum[W-1:0]);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) acc_reg <= '0;
      else if (clr) acc_reg <= '0;
      else if (step) acc_reg <= acc_next;
   end
endmodule : svgl_integ

// >>> src/svgl_top.sv
/*
 Nested servo gain loop for one axis with its AHB-Lite register file.
 Assumes servo_tick and position/velocity inputs synchronous to hclk.
*/
`timescale 1ns/1ps
module svgl_top
   import svgl_pkg::*;
#(
   parameter int W = SVGL_W
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic servo_tick,
   input wire logic signed [W-1:0] cmd_pos,
   input wire logic signed [W-1:0] act_pos,
   input wire logic signed [W-1:0] act_vel,
   output logic signed [W-1:0] servo_out,
   output logic out_valid,
   output logic out_sat
);
   if (W != SVGL_W) begin : g_bad_width
      $error("svgl_top: data width must be 32");
   end
   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   svgl_ctrl_type ctrl_reg;
   svgl_gain_type shadow_reg;
   svgl_gain_type act_reg;
   logic [31:0] limit_reg;
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic sat_reg;
   logic freeze_reg;
   svgl_state_type st_reg;
   svgl_state_type st_next;
   wire logic take = hsel & hready & htrans[1];
   wire logic locked = ctrl_reg.run_lock | ctrl_reg.fb_on;
   wire logic wr_ctrl = wr_pend_reg & (wr_addr_reg == ADDR_CTRL);
   wire logic wr_limit = wr_pend_reg & (wr_addr_reg == ADDR_LIMIT);
   // Gain writes dropped while locked
   wire logic wr_gain = wr_pend_reg & ~locked;
   wire logic [15:0] wd16 = hwdata[15:0];
   svgl_gain_type shadow_next;
   assign shadow_next.kpp = (wr_gain && wr_addr_reg == ADDR_KPP) ? wd16 : shadow_reg.kpp;
   assign shadow_next.kpi = (wr_gain && wr_addr_reg == ADDR_KPI) ? wd16 : shadow_reg.kpi;
   assign shadow_next.kvp = (wr_gain && wr_addr_reg == ADDR_KVP) ? wd16 : shadow_reg.kvp;
   assign shadow_next.kvi = (wr_gain && wr_addr_reg == ADDR_KVI) ? wd16 : shadow_reg.kvi;
   assign shadow_next.kvff = (wr_gain && wr_addr_reg == ADDR_KVFF) ? wd16 : shadow_reg.kvff;
   assign shadow_next.kaff = (wr_gain && wr_addr_reg == ADDR_KAFF) ? wd16 : shadow_reg.kaff;
   wire logic [31:0] stat_word = {29'h0, freeze_reg, (st_reg != ST_IDLE), sat_reg};
   wire logic [7:0] ra = haddr[7:0];
   wire logic hit_hi = haddr[31:8] == 24'h00_0000;
   wire logic [31:0] rd_mux =
      !hit_hi ? 32'h0000_0000 :
      (ra == ADDR_CTRL) ? {28'h000_0000, ctrl_reg} :
      (ra == ADDR_STAT) ? stat_word :
      (ra == ADDR_KPP) ? {16'h0000, shadow_reg.kpp} :
      (ra == ADDR_KPI) ? {16'h0000, shadow_reg.kpi} :
      (ra == ADDR_KVP) ? {16'h0000, shadow_reg.kvp} :
      (ra == ADDR_KVI) ? {16'h0000, shadow_reg.kvi} :
      (ra == ADDR_KVFF) ? {16'h0000, shadow_reg.kvff} :
      (ra == ADDR_KAFF) ? {16'h0000, shadow_reg.kaff} :
      (ra == ADDR_LIMIT) ? limit_reg :
      (ra == ADDR_OUT) ? servo_out : 32'h0000_0000;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wr_pend_reg <= take & hwrite & hit_hi;
         wr_addr_reg <= ra;
         hrdata <= (take & ~hwrite) ? rd_mux : 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= '0;
         limit_reg <= LIMIT_RST;
         shadow_reg <= '{GAIN_ZERO, GAIN_ZERO, GAIN_ZERO, GAIN_ZERO, GAIN_UNITY, GAIN_UNITY};
      end else begin
         if (wr_ctrl) ctrl_reg <= svgl_ctrl_type'(hwdata[CTRL_W-1:0]);
         if (wr_limit) limit_reg <= {1'b0, hwdata[30:0]};
         shadow_reg <= shadow_next;
      end
   end
   // ----------------------------------------
   // Update sequencer
   // ----------------------------------------
   wire logic start = (st_reg == ST_IDLE) & servo_tick;
   logic signed [W-1:0] cpos_prev_reg;
   logic signed [W-1:0] cvel_reg;
   logic signed [W-1:0] cacc_reg;
   logic signed [W-1:0] perr_reg;
   logic signed [W-1:0] avel_reg;
   logic signed [W-1:0] vcmd_reg;
   logic signed [W-1:0] trq_reg;
   wire logic signed [W-1:0] cvel_new = cmd_pos - cpos_prev_reg;
   wire logic torque = ctrl_reg.torque_mode;
   // Integrators stop on saturation, or in motion when hold is set
   wire logic freeze_new = sat_reg | (ctrl_reg.hold_en & (cvel_new != '0));
   always_comb begin
      unique case (st_reg)
         ST_IDLE: st_next = start ? ST_PERR : ST_IDLE;
         ST_PERR: st_next = ST_PINT;
         ST_PINT: st_next = ST_VFF;
         ST_VFF: st_next = ST_VLOOP;
         ST_VLOOP: st_next = ST_VINT;
         ST_VINT: st_next = ST_AFF;
         ST_AFF: st_next = ST_OUT;
         ST_OUT: st_next = ST_IDLE;
         default: st_next = ST_IDLE;
      endcase
   end
   // ----------------------------------------
   // Shared multiply-accumulate
   // ----------------------------------------
   logic signed [W-1:0] pint_reg;
   logic signed [W-1:0] vint_reg;
   wire logic signed [W-1:0] verr = vcmd_reg - avel_reg;
   wire logic signed [W-1:0] mac_acc =
      (st_reg == ST_PERR) ? '0 :
      (st_reg == ST_VLOOP) ? '0 :
      (st_reg == ST_VINT || st_reg == ST_AFF) ? trq_reg : vcmd_reg;
   wire logic signed [W-1:0] mac_a =
      (st_reg == ST_PERR) ? perr_reg :
      (st_reg == ST_PINT) ? pint_reg :
      (st_reg == ST_VFF) ? cvel_reg :
      (st_reg == ST_VLOOP) ? verr :
      (st_reg == ST_VINT) ? vint_reg : cacc_reg;
   wire logic signed [SVGL_G-1:0] mac_g =
      (st_reg == ST_PERR) ? act_reg.kpp :
      (st_reg == ST_PINT) ? act_reg.kpi :
      (st_reg == ST_VFF) ? act_reg.kvff :
      (st_reg == ST_VLOOP) ? act_reg.kvp :
      (st_reg == ST_VINT) ? act_reg.kvi : act_reg.kaff;
   logic signed [W-1:0] mac_y;
   // Term clamps stay internal; only the drive limit raises the flag
   svgl_sat_mac #(.W(W), .G(SVGL_G), .F(SVGL_F)) u_mac (
      .acc(mac_acc),
      .a(mac_a),
      .g(mac_g),
      .y(mac_y),
      .sat()
   );
   // ----------------------------------------
   // Integrators
   // ----------------------------------------
   wire logic pint_step = (st_reg == ST_PERR) & ~freeze_reg;
   wire logic vint_step = (st_reg == ST_VLOOP) & ~freeze_reg & torque;
   svgl_integ #(.W(W)) u_pint (
      .hclk(hclk),
      .hresetn(hresetn),
      .clr(~ctrl_reg.fb_on),
      .step(pint_step),
      .err(perr_reg),
      .acc_reg(pint_reg)
   );
   svgl_integ #(.W(W)) u_vint (
      .hclk(hclk),
      .hresetn(hresetn),
      .clr(~ctrl_reg.fb_on | ~torque),
      .step(vint_step),
      .err(verr),
      .acc_reg(vint_reg)
   );
   // ----------------------------------------
   // Loop terms and output
   // ----------------------------------------
   wire logic signed [W-1:0] lim = limit_reg;
   wire logic out_hi = trq_reg > lim;
   wire logic out_lo = trq_reg < -lim;
   // Clamp to the programmed drive range
   wire logic signed [W-1:0] clamped = out_hi ? lim : (out_lo ? -lim : trq_reg);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) st_reg <= ST_IDLE;
      else st_reg <= st_next;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         act_reg <= '{GAIN_ZERO, GAIN_ZERO, GAIN_ZERO, GAIN_ZERO, GAIN_UNITY, GAIN_UNITY};
         cpos_prev_reg <= '0;
         cvel_reg <= '0;
         cacc_reg <= '0;
         perr_reg <= '0;
         avel_reg <= '0;
         freeze_reg <= 1'b0;
      end else if (start) begin
         act_reg <= shadow_reg;
         cpos_prev_reg <= cmd_pos;
         cvel_reg <= cvel_new;
         cacc_reg <= cvel_new - cvel_reg;
         perr_reg <= cmd_pos - act_pos;
         avel_reg <= act_vel;
         freeze_reg <= freeze_new;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         vcmd_reg <= '0;
         trq_reg <= '0;
      end else begin
         unique case (st_reg)
            ST_PERR: vcmd_reg <= mac_y;
            ST_PINT: vcmd_reg <= mac_y;
            ST_VFF: vcmd_reg <= mac_y;
            // Velocity drive takes the velocity command itself
            ST_VLOOP: trq_reg <= torque ? mac_y : vcmd_reg;
            ST_VINT: trq_reg <= torque ? mac_y : trq_reg;
            ST_AFF: trq_reg <= torque ? mac_y : trq_reg;
            default: trq_reg <= trq_reg;
         endcase
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         servo_out <= '0;
         out_valid <= 1'b0;
         out_sat <= 1'b0;
         sat_reg <= 1'b0;
      end else begin
         out_valid <= st_reg == ST_OUT;
         if (st_reg == ST_OUT) begin
            servo_out <= clamped;
            sat_reg <= out_hi | out_lo;
            out_sat <= out_hi | out_lo;
         end
      end
   end
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_walk;
      (st_reg == ST_PERR) ##1 (st_reg == ST_PINT) ##1 (st_reg == ST_VFF) ##1 (st_reg == ST_VLOOP)
         ##1 (st_reg == ST_VINT) ##1 (st_reg == ST_AFF) ##1 (st_reg == ST_OUT);
   endsequence
   sequence s_done;
      (st_reg == ST_IDLE && out_valid);
   endsequence
   AST_WALK: assert property (start |=> s_walk ##1 s_done)
      else $error("update sequence broken");
   AST_LIMIT: assert property (out_valid |-> (servo_out <= lim && servo_out >= -lim))
      else $error("output beyond limit");
   AST_SATFLAG: assert property ((st_reg == ST_OUT && out_hi) |=> out_sat && servo_out == lim)
      else $error("clamp not flagged");
   AST_LOCK: assert property ((wr_pend_reg && locked) |=> $stable(shadow_reg))
      else $error("gain written while locked");
   AST_BOUNDARY: assert property (!start |=> $stable(act_reg))
      else $error("gains changed mid update");
   AST_FREEZE: assert property ((st_reg == ST_PERR && freeze_reg) |=> $stable(pint_reg))
      else $error("integrator ran while frozen");
   AST_HOLD: assert property ((start && ctrl_reg.hold_en && cvel_new != 0) |=> freeze_reg [*8])
      else $error("hold ignored in motion");
   AST_RUN: assert property ((start && !ctrl_reg.hold_en && !sat_reg) |=> !freeze_reg)
      else $error("integrator frozen without cause");
   AST_NOAFF: assert property ((st_reg == ST_AFF && !torque) |=> $stable(trq_reg))
      else $error("accel feedforward in velocity mode");
   AST_VMODE: assert property ((!ctrl_reg.torque_mode) |=> vint_reg == 0)
      else $error("velocity integral active in velocity mode");
endmodule : svgl_top

// >>> bench/svgl_drive_model.sv
/*
 Stand-in for the servo drive and motor on the far side of the gain loop.
 Assumes servo_out and out_valid arrive on hclk; the bench may pin feedback.
*/
`timescale 1ns/1ps
module svgl_drive_model
   import svgl_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic signed [SVGL_W-1:0] servo_out,
   input wire logic out_valid,
   input wire logic clamp_motor,
   input wire logic signed [SVGL_W-1:0] clamp_pos,
   input wire logic signed [SVGL_W-1:0] clamp_vel,
   output logic signed [SVGL_W-1:0] act_pos,
   output logic signed [SVGL_W-1:0] act_vel
);
   // ----------------------------------------
   // Motor state
   // ----------------------------------------
   logic signed [SVGL_W-1:0] pos_reg;
   logic signed [SVGL_W-1:0] vel_reg;
   // Ideal drive: the command becomes velocity at once, no lag
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pos_reg <= '0;
         vel_reg <= '0;
      end else if (out_valid) begin
         vel_reg <= servo_out;
         pos_reg <= pos_reg + servo_out;
      end
   end
   // Pinned feedback makes loop outputs exactly predictable
   assign act_pos = clamp_motor ? clamp_pos : pos_reg;
   assign act_vel = clamp_motor ? clamp_vel : vel_reg;
endmodule : svgl_drive_model

// >>> bench/testbench.sv
/*
 Self-checking bench for the nested servo gain loop.
 Assumes the design package, a single AHB-Lite master and the drive model.
*/
`timescale 1ns/1ps
module testbench
   import svgl_pkg::*;
;
   // ----------------------------------------
   // Design and partner
   // ----------------------------------------
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'b010;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic hreadyout, hresp, out_valid, out_sat;
   logic servo_tick = 1'b0;
   logic clamp_motor = 1'b1;
   logic signed [SVGL_W-1:0] cmd_pos = '0;
   logic signed [SVGL_W-1:0] clamp_pos = '0;
   logic signed [SVGL_W-1:0] clamp_vel = '0;
   logic signed [SVGL_W-1:0] act_pos, act_vel, servo_out;
   int n_errors = 0;
   int checks = 0;
   int cyc = 0;
   int prev_cmd = 0;
   int prev_vel = 0;
   logic [31:0] ctrl = 32'h0000_0000;
   logic [31:0] lim = LIMIT_RST;
   logic [15:0] g [2:7];
   logic signed [31:0] o [0:5];
   logic [7:0] rst_a [0:10];

   always #5 hclk = ~hclk;

   svgl_top u_svgl_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .servo_tick(servo_tick), .cmd_pos(cmd_pos), .act_pos(act_pos),
      .act_vel(act_vel), .servo_out(servo_out), .out_valid(out_valid), .out_sat(out_sat));
   svgl_drive_model u_svgl_drive_model (.hclk(hclk), .hresetn(hresetn), .servo_out(servo_out),
      .out_valid(out_valid), .clamp_motor(clamp_motor), .clamp_pos(clamp_pos), .clamp_vel(clamp_vel),
      .act_pos(act_pos), .act_vel(act_vel));

   // ----------------------------------------
   // Bus and servo tasks
   // ----------------------------------------
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : summarize

   // Hang guard: whole run needs a few hundred cycles
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         summarize();
      end
   end

   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
      checks++;
      if (s !== e) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask : cmp

   task automatic ahb(input logic [7:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
      cmp("hresp", 32'h0000_0000, {31'h0, hresp});
   endtask : ahb

   // Mirrors software view: gains stick only while unlocked
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      ahb(a, 1'b1, d, q);
      if (a == ADDR_CTRL) ctrl = d;
      if (a == ADDR_LIMIT) lim = {1'b0, d[30:0]};
      if (a >= ADDR_KPP && a <= ADDR_KAFF && ctrl[3:2] == 2'b00) g[a[4:2]] = d[15:0];
   endtask : wr

   task automatic rd_cmp(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      ahb(a, 1'b0, 32'h0000_0000, q);
      cmp($sformatf("reg %h", a), e, q);
   endtask : rd_cmp

   // Integrator terms are not modelled; callers keep them zero when chk is set
   task automatic step(input int c, input int ap, input int av, input logic [15:0] late, input bit chk,
      output logic signed [31:0] r);
      longint cv, ca, vc, t, e;
      int k;
      cv = c - prev_cmd;
      ca = cv - prev_vel;
      prev_cmd = c;
      prev_vel = int'(cv);
      vc = ((longint'($signed(g[2])) * (c - ap)) >>> 8) + ((longint'($signed(g[6])) * cv) >>> 8);
      t = ctrl[1] ? ((longint'($signed(g[4])) * (vc - av)) >>> 8) + ((longint'($signed(g[7])) * ca) >>> 8) : vc;
      e = (t > longint'(lim)) ? longint'(lim) : (t < -longint'(lim)) ? -longint'(lim) : t;
      @(posedge hclk);
      cmd_pos <= c;
      clamp_pos <= ap;
      clamp_vel <= av;
      servo_tick <= 1'b1;
      @(posedge hclk);
      servo_tick <= 1'b0;
      if (late !== 16'h0000) wr(ADDR_KPP, {16'h0000, late});
      k = 0;
      while (out_valid !== 1'b1 && k < 30) begin
         @(posedge hclk);
         k++;
      end
      cmp("update done", 32'h0000_0001, {31'h0, out_valid});
      r = servo_out;
      if (chk) begin
         cmp("servo_out", e[31:0], r);
         cmp("out_sat", {31'h0, (t != e)}, {31'h0, out_sat});
      end
   endtask : step

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      g = '{GAIN_ZERO, GAIN_ZERO, GAIN_ZERO, GAIN_ZERO, GAIN_UNITY, GAIN_UNITY};
      rst_a = '{ADDR_CTRL, ADDR_STAT, ADDR_KPP, ADDR_KPI, ADDR_KVP, ADDR_KVI, ADDR_KVFF, ADDR_KAFF,
         ADDR_LIMIT, ADDR_OUT, 8'h40};
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 11; i++)
         rd_cmp(rst_a[i], (i == 6 || i == 7) ? {16'h0000, GAIN_UNITY} : (i == 8) ? LIMIT_RST : 32'h0000_0000);
      $display("test reset values done");
      wr(ADDR_KVFF, 32'h0000_0000);
      wr(ADDR_KAFF, 32'h0000_0000);
      wr(ADDR_KPP, 32'h0000_0200);
      step(100, 40, 0, 16'h0000, 1'b1, o[0]);
      step(100, 40, 0, 16'h0000, 1'b1, o[0]);
      wr(ADDR_KVFF, 32'h0000_0100);
      step(150, 150, 0, 16'h0000, 1'b1, o[0]);
      $display("test position loop done");
      wr(ADDR_KPP, 32'h0000_0100);
      wr(ADDR_KVFF, 32'h0000_0000);
      step(150, 90, 0, 16'h0300, 1'b1, o[0]);
      g[2] = 16'h0300;
      step(150, 90, 0, 16'h0000, 1'b1, o[0]);
      $display("test gain boundary done");
      wr(ADDR_KPP, 32'h0000_0000);
      wr(ADDR_KVP, 32'h0000_0200);
      wr(ADDR_KAFF, 32'h0000_0100);
      wr(ADDR_CTRL, 32'h0000_0002);
      step(150, 150, -20, 16'h0000, 1'b1, o[0]);
      step(250, 250, -20, 16'h0000, 1'b1, o[0]);
      wr(ADDR_CTRL, 32'h0000_0000);
      step(400, 400, -20, 16'h0000, 1'b1, o[0]);
      $display("test velocity loop done");
      wr(ADDR_KPP, 32'h0000_0100);
      wr(ADDR_LIMIT, 32'h0000_0032);
      step(400, -600, 0, 16'h0000, 1'b1, o[0]);
      step(400, 1400, 0, 16'h0000, 1'b1, o[0]);
      rd_cmp(ADDR_STAT, 32'h0000_0005);
      step(400, 390, 0, 16'h0000, 1'b1, o[0]);
      $display("test output clamp done");
      for (int m = 0; m < 2; m++) begin
         wr(ADDR_CTRL, m ? 32'h0000_0004 : 32'h0000_0008);
         wr(ADDR_KVP, 32'h0000_0700);
         rd_cmp(ADDR_KVP, {16'h0000, g[4]});
      end
      $display("test gain lock done");
      for (int m = 0; m < 2; m++) begin
         wr(ADDR_CTRL, 32'h0000_0000);
         wr(ADDR_LIMIT, LIMIT_RST);
         for (int a = 8; a <= 28; a += 4) wr(a[7:0], 32'h0000_0000);
         wr(m ? ADDR_KVI : ADDR_KPI, {16'h0000, GAIN_UNITY});
         wr(ADDR_CTRL, 32'h0000_0008 | {30'h0, m[0], 1'b0});
         step(500, 490, -10, 16'h0000, 1'b0, o[0]);
         step(500, 490, -10, 16'h0000, 1'b0, o[1]);
         cmp("integral growth", 32'h0000_000A, o[1] - o[0]);
         wr(ADDR_CTRL, ctrl | 32'h0000_0001);
         step(505, 495, -10, 16'h0000, 1'b0, o[2]);
         step(510, 500, -10, 16'h0000, 1'b0, o[3]);
         cmp("held integral", 32'h0000_0000, o[3] - o[2]);
         wr(ADDR_CTRL, ctrl & 32'h0000_000E);
         step(515, 505, -10, 16'h0000, 1'b0, o[4]);
         step(520, 510, -10, 16'h0000, 1'b0, o[5]);
         cmp("moving integral", 32'h0000_000A, o[5] - o[4]);
      end
      $display("test integrators done");
      clamp_motor <= 1'b0;
      wr(ADDR_CTRL, 32'h0000_0000);
      wr(ADDR_KPP, 32'h0000_0100);
      step(600, 0, 0, 16'h0000, 1'b0, o[0]);
      step(600, 0, 0, 16'h0000, 1'b0, o[1]);
      rd_cmp(ADDR_OUT, o[1]);
      $display("test free motor done");
      summarize();
   end
endmodule : testbench
